// file: rtl/pslc_control.sv
// Top level of the synthesizer digital control: latches, dividers, detector and lock logic.
// Function
// - Fourteen-bit reference divider, ratios 1 to 16383, feeds the phase detector.
// - Detector compares reference with feedback divided by prescaler times coarse plus swallow.
// - Two reference latch bits pick the antibacklash pulse width.
// - Three-bit control field chooses what the multiplexed output pin shows.
// - Precision off: lock asserts after three cycles with error under 15 ns.
// - Precision on: lock needs five consecutive cycles with error under 15 ns.
// - Lock stays high until one cycle shows error above 25 ns.
// - Analog lock is open drain, high when locked with narrow low pulses.
// - Bits arrive first bit highest, shifted on each serial clock rising edge.
// - Load strobe rising edge copies the shift register into one latch.
// - Two lowest word bits choose control, reference, feedback or test latch.
// - Band selection runs at power-up and on every feedback latch write.
// - Band selection lasts five band clock cycles with tuning held at reference.
// - Band clock divider divides by 1, 2, 4 or 8; host keeps it slow.
// - Feedback latch bit 22 enables divide-by-two of the oscillator output.
// - Two control bits choose core current among four steps.
// - Two control bits choose output stage tail current among four levels.
// - With mute set, output stage supply stays off until digital lock.
// - Control latch fields sit at their fixed bit positions.
// - Feedback latch fields sit at their fixed bit positions.
// - Chip enable low powers down and three-states the pump.
`timescale 1ns/10ps
`default_nettype none
module pslc_control
	import pslc_pkg::*;
#(
	parameter int REF_W = 14,
	parameter int COARSE_W = 13,
	parameter int SWALLOW_W = 5,
	parameter int ERR_W = 8
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic serialClock,
	input wire logic serialData,
	input wire logic loadStrobe,
	input wire logic chipEnable,
	input wire logic referenceIn,
	input wire logic prescalerIn,
	output logic modulusSelect,
	output logic pumpUp,
	output logic pumpDown,
	output logic pumpThreeState,
	output logic [5:0] pumpCurrent,
	output logic pumpGain,
	output logic [1:0] prescalerSel,
	output logic [1:0] coreCurrent,
	output logic [1:0] outputLevel,
	output logic outputStageOn,
	output logic divideByTwo,
	output logic divideByTwoSelect,
	output logic tuneToReference,
	output logic bandSelectBusy,
	output logic digitalLock,
	output logic analogLockOut,
	output logic analogLockOe,
	output logic multiplexedOut,
	output logic multiplexedOutOe,
	output logic poweredDown
);
	pslc_word_if wordBus ();

	logic [WORD_W-1:0] deviceControlWord_reg;
	logic [WORD_W-1:0] referenceDividerWord_reg;
	logic [WORD_W-1:0] feedbackDividerWord_reg;
	logic feedbackWrite_reg;
	logic [2:0] pinMeta_reg, pinSync_reg, pinLast_reg;
	logic ceSync, refEdge, preEdge;
	logic [REF_W-1:0] refCount_reg, refRatio;
	logic refPulse_reg;
	logic [COARSE_W-1:0] coarseCount_reg, coarseRatio;
	logic [SWALLOW_W-1:0] swallowCount_reg, swallowRatio;
	logic fbPulse_reg;
	logic modulus_reg;
	logic holdCounters;
	logic up_reg, down_reg;
	logic [2:0] backlash_reg;
	logic [ERR_W-1:0] error_reg;
	logic pfdDone_reg;
	logic [ERR_W-1:0] lastError_reg;
	logic [2:0] goodCount_reg;
	logic lock_reg;
	logic [2:0] lockNeed;
	logic [2:0] bandDiv_reg;
	logic [2:0] bandDivRatio;
	logic bandTick;
	logic bandBusy_reg;
	logic [2:0] bandCount_reg;
	logic multiplexed_output_pin_reg, muxOe_reg;
	logic multiplexed_output_pin_next, muxOe_next;
	logic analogLow;

	pslc_serial_shift i_pslc_serial_shift (
		.clk(clk),
		.reset(reset),
		.serialClock(serialClock),
		.serialData(serialData),
		.loadStrobe(loadStrobe),
		.wordOut(wordBus)
	);

	// A word is taken only when the strobe edge arrives; test latch words are discarded.
	always_ff @(posedge clk) begin
		if (reset) begin
			deviceControlWord_reg <= WORD_RESET;
			referenceDividerWord_reg <= WORD_RESET;
			feedbackDividerWord_reg <= WORD_RESET;
			feedbackWrite_reg <= 1'b0;
		end else begin
			feedbackWrite_reg <= 1'b0;
			if (wordBus.load) begin
				case (wordBus.word[1:0])
					SEL_CONTROL: begin
						deviceControlWord_reg <= wordBus.word;
					end
					SEL_REFDIV: begin
						referenceDividerWord_reg <= wordBus.word;
					end
					SEL_FEEDBACK: begin
						feedbackDividerWord_reg <= wordBus.word;
						feedbackWrite_reg <= 1'b1;
					end
					default: begin
						feedbackWrite_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	// Chip enable, reference and prescaler edges come from pins and are synchronised.
	always_ff @(posedge clk) begin
		if (reset) begin
			pinMeta_reg <= 3'h0;
			pinSync_reg <= 3'h0;
			pinLast_reg <= 3'h0;
		end else begin
			pinMeta_reg <= {chipEnable, referenceIn, prescalerIn};
			pinSync_reg <= pinMeta_reg;
			pinLast_reg <= pinSync_reg;
		end
	end

	assign ceSync = pinSync_reg[2];
	assign refEdge = pinSync_reg[1] & ~pinLast_reg[1];
	assign preEdge = pinSync_reg[0] & ~pinLast_reg[0];

	// Field decode of the three latches.
	assign prescalerSel = deviceControlWord_reg[CTL_PRESCALER_POS +: 2];
	assign pumpCurrent = deviceControlWord_reg[CTL_PUMP_CURRENT_POS +: 6];
	assign outputLevel = deviceControlWord_reg[CTL_OUTPUT_LEVEL_POS +: 2];
	assign coreCurrent = deviceControlWord_reg[CTL_CORE_CURRENT_POS +: 2];
	assign pumpGain = deviceControlWord_reg[CTL_PUMP_GAIN_POS]
		| feedbackDividerWord_reg[FB_PUMP_GAIN_POS];
	assign divideByTwo = feedbackDividerWord_reg[FB_DIVIDE_BY_TWO_BIT_POS];
	assign divideByTwoSelect = feedbackDividerWord_reg[FB_DIVIDE_BY_TWO_BIT_SELECT_POS];
	assign refRatio = referenceDividerWord_reg[REF_COUNT_POS +: REF_W];
	assign coarseRatio = feedbackDividerWord_reg[FB_COARSE_POS +: COARSE_W];
	assign swallowRatio = feedbackDividerWord_reg[FB_SWALLOW_POS +: SWALLOW_W];
	assign bandDivRatio = 3'((4'h1 << referenceDividerWord_reg[REF_BAND_DIV_POS +: 2]) - 4'h1);
	assign lockNeed = referenceDividerWord_reg[REF_LOCK_PRECISION_POS]
		? 3'(LOCK_COUNT_PRECISE) : 3'(LOCK_COUNT_NORMAL);

	// Chip enable low or the first power-down bit stops the dividers, detector, lock and output stage; the serial port and multiplexed output keep running.
	assign poweredDown = ~ceSync | deviceControlWord_reg[CTL_POWERDOWN_POS];
	assign pumpThreeState = poweredDown | deviceControlWord_reg[CTL_PUMP_TRISTATE_POS];
	assign holdCounters = poweredDown | deviceControlWord_reg[CTL_COUNTER_CLEAR_POS];

	// Reference divider; a ratio of zero behaves as one so the detector never starves.
	always_ff @(posedge clk) begin
		if (reset || holdCounters) begin
			refCount_reg <= '0;
			refPulse_reg <= 1'b0;
		end else begin
			refPulse_reg <= 1'b0;
			if (refEdge) begin
				if (refCount_reg + REF_W'(1) >= refRatio) begin
					refCount_reg <= '0;
					refPulse_reg <= 1'b1;
				end else begin
					refCount_reg <= refCount_reg + REF_W'(1);
				end
			end
		end
	end

	// Pulse swallow: the prescaler runs at its higher modulus for the first swallow
	// count of each coarse period, giving a total of modulus times coarse plus swallow.
	always_ff @(posedge clk) begin
		if (reset || holdCounters) begin
			coarseCount_reg <= '0;
			swallowCount_reg <= '0;
			fbPulse_reg <= 1'b0;
			modulus_reg <= 1'b0;
		end else begin
			fbPulse_reg <= 1'b0;
			modulus_reg <= (swallowCount_reg < swallowRatio);
			if (preEdge) begin
				if (swallowCount_reg < swallowRatio) begin
					swallowCount_reg <= swallowCount_reg + SWALLOW_W'(1);
				end
				if (coarseCount_reg + COARSE_W'(1) >= coarseRatio) begin
					coarseCount_reg <= '0;
					swallowCount_reg <= '0;
					fbPulse_reg <= 1'b1;
				end else begin
					coarseCount_reg <= coarseCount_reg + COARSE_W'(1);
				end
			end
		end
	end

	assign modulusSelect = modulus_reg;

	// Phase detector: once both sides have fired, both stay on for the antibacklash
	// width so that tiny errors still produce pump action and no dead zone remains.
	always_ff @(posedge clk) begin
		if (reset || holdCounters) begin
			up_reg <= 1'b0;
			down_reg <= 1'b0;
			backlash_reg <= 3'h0;
			pfdDone_reg <= 1'b0;
		end else begin
			pfdDone_reg <= 1'b0;
			if (up_reg && down_reg) begin
				if (backlash_reg >= 3'(referenceDividerWord_reg[REF_ANTIBACKLASH_POS +: 2])) begin
					up_reg <= 1'b0;
					down_reg <= 1'b0;
					backlash_reg <= 3'h0;
					pfdDone_reg <= 1'b1;
				end else begin
					backlash_reg <= backlash_reg + 3'h1;
				end
			end else begin
				if (refPulse_reg) begin
					up_reg <= 1'b1;
				end
				if (fbPulse_reg) begin
					down_reg <= 1'b1;
				end
			end
		end
	end

	// Polarity swaps pump direction for inverting loop filters.
	assign pumpUp = ~pumpThreeState
		& (deviceControlWord_reg[CTL_POLARITY_POS] ? up_reg : down_reg);
	assign pumpDown = ~pumpThreeState
		& (deviceControlWord_reg[CTL_POLARITY_POS] ? down_reg : up_reg);

	// Phase error is the time only one side is on, measured in clock periods.
	always_ff @(posedge clk) begin
		if (reset || holdCounters) begin
			error_reg <= '0;
			lastError_reg <= '0;
		end else if (pfdDone_reg) begin
			lastError_reg <= error_reg;
			error_reg <= '0;
		end else if ((up_reg ^ down_reg) && error_reg != '1) begin
			error_reg <= error_reg + ERR_W'(1);
		end
	end

	// Digital lock; resolution is one clock period, so short thresholds round up.
	always_ff @(posedge clk) begin
		if (reset || holdCounters) begin
			goodCount_reg <= 3'h0;
			lock_reg <= 1'b0;
		end else if (pfdDone_reg) begin
			if (error_reg < ERR_W'(LOCK_SET_CYC)) begin
				if (goodCount_reg + 3'h1 >= lockNeed) begin
					lock_reg <= 1'b1;
				end else begin
					goodCount_reg <= goodCount_reg + 3'h1;
				end
			end else begin
				goodCount_reg <= 3'h0;
			end
			if (error_reg > ERR_W'(LOCK_CLEAR_CYC)) begin
				lock_reg <= 1'b0;
				goodCount_reg <= 3'h0;
			end
		end
	end

	assign digitalLock = lock_reg;

	// Open drain analog lock pulls low only while one side of the detector is on.
	// It follows the gated pump, so a part in power down never pulls the line.
	assign analogLow = pumpUp ^ pumpDown;
	assign analogLockOut = 1'b0;
	assign analogLockOe = analogLow;

	// Band select clock: the reference pulse divided by 1, 2, 4 or 8.
	always_ff @(posedge clk) begin
		if (reset || holdCounters) begin
			bandDiv_reg <= 3'h0;
		end else if (refPulse_reg) begin
			if (bandDiv_reg >= bandDivRatio) begin
				bandDiv_reg <= 3'h0;
			end else begin
				bandDiv_reg <= bandDiv_reg + 3'h1;
			end
		end
	end

	assign bandTick = refPulse_reg && (bandDiv_reg >= bandDivRatio);

	// Band select is busy out of reset, so it also runs at power-up.
	always_ff @(posedge clk) begin
		if (reset) begin
			bandBusy_reg <= 1'b1;
			bandCount_reg <= 3'h0;
		end else if (feedbackWrite_reg) begin
			bandBusy_reg <= 1'b1;
			bandCount_reg <= 3'h0;
		end else if (bandBusy_reg && bandTick) begin
			if (bandCount_reg + 3'h1 >= 3'(BAND_SELECT_CYCLES)) begin
				bandBusy_reg <= 1'b0;
				bandCount_reg <= 3'h0;
			end else begin
				bandCount_reg <= bandCount_reg + 3'h1;
			end
		end
	end

	assign bandSelectBusy = bandBusy_reg;
	assign tuneToReference = bandBusy_reg;

	// Output stage stays dark until lock when muting is requested.
	assign outputStageOn = ~poweredDown
		& (~deviceControlWord_reg[CTL_MUTE_POS] | lock_reg);

	always_comb begin
		multiplexed_output_pin_next = 1'b0;
		muxOe_next = 1'b1;
		case (deviceControlWord_reg[CTL_OUTPUT_SELECT_POS +: 3])
			MUX_TRISTATE: begin
				muxOe_next = 1'b0;
			end
			MUX_DIGITAL_LOCK: begin
				multiplexed_output_pin_next = lock_reg;
			end
			MUX_FEEDBACK: begin
				multiplexed_output_pin_next = fbPulse_reg;
			end
			MUX_HIGH: begin
				multiplexed_output_pin_next = 1'b1;
			end
			MUX_REFERENCE: begin
				multiplexed_output_pin_next = refPulse_reg;
			end
			MUX_ANALOG_LOCK: begin
				muxOe_next = analogLow;
			end
			default: begin
				multiplexed_output_pin_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			multiplexed_output_pin_reg <= 1'b0;
			muxOe_reg <= 1'b0;
		end else begin
			multiplexed_output_pin_reg <= multiplexed_output_pin_next;
			muxOe_reg <= muxOe_next;
		end
	end

	assign multiplexedOut = multiplexed_output_pin_reg;
	assign multiplexedOutOe = muxOe_reg;
endmodule
`default_nettype wire

// file: rtl/pslc_pkg.sv
// Package with latch layouts, reset values and timing counts for the synthesizer control.
package pslc_pkg;
	localparam int WORD_W = 24;
	localparam int CLK_PERIOD_NS = 4;
	// Latch select codes held in the two lowest word bits.
	localparam logic [1:0] SEL_CONTROL = 2'h0;
	localparam logic [1:0] SEL_REFDIV = 2'h1;
	localparam logic [1:0] SEL_FEEDBACK = 2'h2;
	localparam logic [1:0] SEL_TEST = 2'h3;
	localparam logic [23:0] WORD_RESET = 24'h000000;
	// Control latch fields.
	localparam int CTL_PRESCALER_POS = 22;
	localparam int CTL_POWERDOWN_POS = 20;
	localparam int CTL_PUMP_CURRENT_POS = 14;
	localparam int CTL_OUTPUT_LEVEL_POS = 12;
	localparam int CTL_MUTE_POS = 11;
	localparam int CTL_PUMP_GAIN_POS = 10;
	localparam int CTL_PUMP_TRISTATE_POS = 9;
	localparam int CTL_POLARITY_POS = 8;
	localparam int CTL_OUTPUT_SELECT_POS = 5;
	localparam int CTL_COUNTER_CLEAR_POS = 4;
	localparam int CTL_CORE_CURRENT_POS = 2;
	// Reference divider latch fields.
	localparam int REF_BAND_DIV_POS = 20;
	localparam int REF_LOCK_PRECISION_POS = 18;
	localparam int REF_ANTIBACKLASH_POS = 16;
	localparam int REF_COUNT_POS = 2;
	// Feedback divider latch fields.
	localparam int FB_DIVIDE_BY_TWO_BIT_SELECT_POS = 23;
	localparam int FB_DIVIDE_BY_TWO_BIT_POS = 22;
	localparam int FB_PUMP_GAIN_POS = 21;
	localparam int FB_COARSE_POS = 8;
	localparam int FB_SWALLOW_POS = 2;
	// Output select codes.
	localparam logic [2:0] MUX_TRISTATE = 3'h0;
	localparam logic [2:0] MUX_DIGITAL_LOCK = 3'h1;
	localparam logic [2:0] MUX_FEEDBACK = 3'h2;
	localparam logic [2:0] MUX_HIGH = 3'h3;
	localparam logic [2:0] MUX_REFERENCE = 3'h4;
	localparam logic [2:0] MUX_ANALOG_LOCK = 3'h5;
	// Lock detect and band select timing.
	localparam int LOCK_SET_NS = 15;
	localparam int LOCK_CLEAR_NS = 25;
	localparam int LOCK_SET_CYC = (LOCK_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_CLEAR_CYC = (LOCK_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_COUNT_NORMAL = 3;
	localparam int LOCK_COUNT_PRECISE = 5;
	localparam int BAND_SELECT_CYCLES = 5;
endpackage

// file: rtl/pslc_word_if.sv
// Interface carrying a completed serial word and its load pulse.
`timescale 1ns/10ps
`default_nettype none
interface pslc_word_if;
	logic [23:0] word;
	logic load;
	modport source (output word, output load);
	modport sink (input word, input load);
endinterface
`default_nettype wire

// file: rtl/pslc_serial_shift.sv
// Serial shift register with pin synchronisers and load strobe edge detection.
`timescale 1ns/10ps
`default_nettype none
module pslc_serial_shift
	import pslc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic serialClock,
	input wire logic serialData,
	input wire logic loadStrobe,
	pslc_word_if.source wordOut
);
	logic [2:0] clkMeta_reg, clkSync_reg;
	logic [2:0] clkLast_reg;
	logic [WORD_W-1:0] shift_reg;
	logic [WORD_W-1:0] word_reg;
	logic load_reg;
	logic clkRise, loadRise;

	// Pins are asynchronous, so each passes two flip-flops before use.
	always_ff @(posedge clk) begin
		if (reset) begin
			clkMeta_reg <= 3'h0;
			clkSync_reg <= 3'h0;
			clkLast_reg <= 3'h0;
		end else begin
			clkMeta_reg <= {serialClock, serialData, loadStrobe};
			clkSync_reg <= clkMeta_reg;
			clkLast_reg <= clkSync_reg;
		end
	end

	assign clkRise = clkSync_reg[2] & ~clkLast_reg[2];
	assign loadRise = clkSync_reg[0] & ~clkLast_reg[0];

	// Data is taken from the sample aligned with the clock edge, first bit ends up on top.
	always_ff @(posedge clk) begin
		if (reset) begin
			shift_reg <= WORD_RESET;
		end else if (clkRise) begin
			shift_reg <= {shift_reg[WORD_W-2:0], clkSync_reg[1]};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			word_reg <= WORD_RESET;
			load_reg <= 1'b0;
		end else begin
			load_reg <= loadRise;
			if (loadRise) begin
				word_reg <= shift_reg;
			end
		end
	end

	assign wordOut.word = word_reg;
	assign wordOut.load = load_reg;
endmodule
`default_nettype wire

// file: verification/pslc_host_model.sv
// Host model that drives the three-wire serial programming link.
`timescale 1ns/10ps
`default_nettype none
module pslc_host_model (
	input wire logic clk,
	output logic serialClock,
	output logic serialData,
	output logic loadStrobe
);
	initial begin
		serialClock = 1'b0;
		serialData = 1'b1;
		loadStrobe = 1'b0;
	end
	// Words never end in select 11, since that latch belongs to factory test.
	// The serial clock stays high for four system clocks and low for five, above the three the pins need.
	task automatic send(input logic [23:0] w, input logic doLoad);
		for (int i = 23; i >= 0; i--) begin
			@(posedge clk);
			serialData <= w[i];
			repeat (4) @(posedge clk);
			serialClock <= 1'b1;
			repeat (4) @(posedge clk);
			serialClock <= 1'b0;
		end
		// The released line shows the inverse of the last bit so a stale level cannot pass.
		@(posedge clk);
		serialData <= ~w[0];
		if (doLoad) begin
			repeat (3) @(posedge clk);
			loadStrobe <= 1'b1;
			repeat (4) @(posedge clk);
			loadStrobe <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// file: verification/pslc_control_chk.sv
// Checker of port relations for the synthesizer control, bound into its top module.
`timescale 1ns/10ps
`default_nettype none
module pslc_control_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic loadStrobe,
	input wire logic chipEnable,
	input wire logic pumpUp,
	input wire logic pumpDown,
	input wire logic pumpThreeState,
	input wire logic [5:0] pumpCurrent,
	input wire logic [1:0] prescalerSel,
	input wire logic [1:0] coreCurrent,
	input wire logic [1:0] outputLevel,
	input wire logic outputStageOn,
	input wire logic divideByTwo,
	input wire logic tuneToReference,
	input wire logic bandSelectBusy,
	input wire logic digitalLock,
	input wire logic analogLockOut,
	input wire logic analogLockOe,
	input wire logic poweredDown
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// Six quiet strobe samples mean the last load has long landed.
	sequence s_quiet;
		!loadStrobe [*6];
	endsequence
	sequence s_ce_off;
		!chipEnable [*3];
	endsequence
	a_latch_hold: assert property (s_quiet |->
		$stable({pumpCurrent, prescalerSel, coreCurrent, outputLevel, divideByTwo}))
		else $error("latch changed without a load");
	a_ce_down: assert property (s_ce_off |-> poweredDown)
		else $error("chip enable low did not power down");
	a_pd_tristate: assert property (poweredDown |-> pumpThreeState)
		else $error("pump not three-stated in power down");
	a_pump_quiet: assert property (pumpThreeState |-> !pumpUp && !pumpDown)
		else $error("pump driven while three-stated");
	a_drain_pulse: assert property (analogLockOe == (pumpUp ^ pumpDown) && !analogLockOut)
		else $error("analog lock drain wrong");
	a_tune_busy: assert property (tuneToReference == bandSelectBusy)
		else $error("tuning hold differs from band select");
	a_busy_span: assert property ($rose(bandSelectBusy) |-> bandSelectBusy [*8])
		else $error("band select ended too soon");
	a_stage_lock: assert property (!poweredDown && digitalLock |-> outputStageOn)
		else $error("output stage off while locked");
	a_stage_off: assert property (poweredDown |-> !outputStageOn)
		else $error("output stage on in power down");
endmodule
bind pslc_control pslc_control_chk i_pslc_control_chk (.clk(clk), .reset(reset),
	.loadStrobe(loadStrobe), .chipEnable(chipEnable), .pumpUp(pumpUp), .pumpDown(pumpDown),
	.pumpThreeState(pumpThreeState), .pumpCurrent(pumpCurrent), .prescalerSel(prescalerSel),
	.coreCurrent(coreCurrent), .outputLevel(outputLevel), .outputStageOn(outputStageOn),
	.divideByTwo(divideByTwo), .tuneToReference(tuneToReference),
	.bandSelectBusy(bandSelectBusy), .digitalLock(digitalLock), .analogLockOut(analogLockOut),
	.analogLockOe(analogLockOe), .poweredDown(poweredDown));
`default_nettype wire

// file: verification/pslc_control_tb.sv
// Self-checking testbench for the synthesizer control block.
`timescale 1ns/10ps
`default_nettype none
module pslc_control_tb;
	import pslc_pkg::*;
	localparam logic [23:0] CTL_BASE = 24'h8B590C;
	logic clk, reset, chipEnable, referenceIn, serialClock, serialData, loadStrobe;
	logic pumpThreeState, pumpGain, outputStageOn, divideByTwo, divideByTwoSelect, modulusSelect;
	logic bandSelectBusy, digitalLock, multiplexedOut, multiplexedOutOe, poweredDown;
	logic [5:0] pumpCurrent;
	logic [1:0] prescalerSel, coreCurrent, outputLevel, phase;
	logic [2:0] muxCode [5] = '{MUX_TRISTATE, MUX_DIGITAL_LOCK, MUX_HIGH, 3'h6, MUX_ANALOG_LOCK};
	logic [1:0] muxWant [5] = '{2'h0, 2'h3, 2'h3, 2'h2, 2'h0};
	int n_fail, samples_checked, cycles, busyCycles;
	pslc_host_model i_pslc_host_model (.clk(clk), .serialClock(serialClock),
		.serialData(serialData), .loadStrobe(loadStrobe));
	// Prescaler follows the reference so both dividers see the same edges.
	pslc_control i_pslc_control (.clk(clk), .reset(reset), .serialClock(serialClock),
		.serialData(serialData), .loadStrobe(loadStrobe), .chipEnable(chipEnable),
		.referenceIn(referenceIn), .prescalerIn(referenceIn), .modulusSelect(modulusSelect),
		.pumpUp(),
		.pumpDown(), .pumpThreeState(pumpThreeState), .pumpCurrent(pumpCurrent),
		.pumpGain(pumpGain), .prescalerSel(prescalerSel), .coreCurrent(coreCurrent),
		.outputLevel(outputLevel), .outputStageOn(outputStageOn), .divideByTwo(divideByTwo),
		.divideByTwoSelect(divideByTwoSelect), .tuneToReference(),
		.bandSelectBusy(bandSelectBusy), .digitalLock(digitalLock), .analogLockOut(),
		.analogLockOe(), .multiplexedOut(multiplexedOut), .multiplexedOutOe(multiplexedOutOe),
		.poweredDown(poweredDown));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		reset = 1'b1;
		chipEnable = 1'b1;
		referenceIn = 1'b0;
		phase = 2'h0;
		n_fail = 0;
		samples_checked = 0;
		cycles = 0;
	end
	always @(posedge clk) begin
		phase <= phase + 2'h1;
		cycles <= cycles + 1;
		if (phase == 2'h3) begin
			referenceIn <= ~referenceIn;
		end
		if (cycles == 60000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic put(input logic [23:0] w);
		i_pslc_host_model.send(w, 1'b1);
		#1;
	endtask
	task automatic await_lock(input logic want);
		for (int i = 0; i < 4000 && digitalLock !== want; i++) begin
			@(posedge clk);
			#1;
		end
	endtask
	task automatic close_out();
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		check({bandSelectBusy, multiplexedOutOe, prescalerSel}, 4'h8);
		repeat (3) @(posedge clk);
		#1;
		check(poweredDown, 1'b0);
		// Reference ratio 3, band clock undivided, precision off, written first.
		put(24'h00000D);
		put(CTL_BASE | 24'h000060);
		check({prescalerSel, pumpCurrent}, 8'hAD);
		check({outputLevel, coreCurrent, pumpGain}, 5'h0E);
		check({multiplexedOutOe, multiplexedOut, outputStageOn}, 3'h6);
		i_pslc_host_model.send(24'h000000, 1'b0);
		#1;
		check(prescalerSel, 2'h2);
		// Coarse count 3 is the smallest the host may send.
		put(24'hC00302);
		check({bandSelectBusy, divideByTwo, divideByTwoSelect}, 3'h7);
		// A swallow count of zero leaves the prescaler at its lower modulus throughout.
		check(modulusSelect, 1'b0);
		busyCycles = 0;
		while (bandSelectBusy === 1'b1 && busyCycles < 2000) begin
			@(posedge clk);
			#1;
			busyCycles++;
		end
		check(busyCycles >= 80 && busyCycles <= 130, 1'b1);
		// Pulsing the counter clear realigns both dividers before lock is sought.
		put(CTL_BASE | 24'h000010);
		put(CTL_BASE);
		await_lock(1'b1);
		check({digitalLock, outputStageOn}, 2'h3);
		for (int k = 0; k < 5; k++) begin
			put(CTL_BASE | {16'h0000, muxCode[k], 5'h00});
			check({multiplexedOutOe, multiplexedOut & multiplexedOutOe}, muxWant[k]);
		end
		put(24'h000011);
		await_lock(1'b0);
		check({digitalLock, outputStageOn}, 2'h0);
		// Precision on: three good cycles land near 65 clocks, five near 113, so 90 splits them.
		put(24'h04000D);
		put(CTL_BASE | 24'h000010);
		put(CTL_BASE);
		repeat (90) @(posedge clk);
		#1;
		check(digitalLock, 1'b0);
		await_lock(1'b1);
		check(digitalLock, 1'b1);
		put(CTL_BASE | 24'h100000);
		check({poweredDown, pumpThreeState}, 2'h3);
		put(CTL_BASE);
		check({poweredDown, pumpThreeState}, 2'h0);
		@(posedge clk);
		chipEnable <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		check(poweredDown, 1'b1);
		close_out();
	end
endmodule
`default_nettype wire
